// >>> tcd_pkg.sv
// Constants, field layouts and carrier types of the three channel down timer
package tcd_pkg;

  localparam int NCH = 3;
  localparam int NPS = 2;
  localparam int AW = 8;
  localparam int DW = 32;

  // Byte offsets
  localparam logic [AW-1:0] OFF_PS0 = 8'hA0;
  localparam logic [AW-1:0] OFF_PS1 = 8'hA4;
  localparam logic [AW-1:0] OFF_IRQSTS = 8'hB0;
  localparam logic [4:0] OFF_LOAD = 5'h00;
  localparam logic [4:0] OFF_COUNT = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_IRQCLR = 5'h0C;
  localparam logic [4:0] OFF_POUT = 5'h10;

  // Control register fields
  localparam int CTRL_IE = 0;
  localparam int CTRL_IMM = 1;
  localparam int CTRL_DIV_LSB = 2;
  localparam int CTRL_MODE = 5;
  localparam int CTRL_EN = 7;
  localparam int CTRL_SRC_LSB = 8;

  // Port output control fields
  localparam int POUT_VAL = 0;
  localparam int POUT_OE = 1;
  localparam int POUT_MODE_LSB = 2;

  // Prescaler control fields
  localparam int PS_LD_LSB = 0;
  localparam int PS_DIV_LSB = 13;

  localparam logic [15:0] RST_REG = 16'h0000;

  // Timer input clock is the bus clock over this figure
  localparam int TIN_DIV = 8;

  typedef enum logic [1:0] {
    OM_LEVEL,
    OM_PULSE,
    OM_TOGGLE,
    OM_RSVD
  } tcd_omode_e;

  typedef struct packed {
    logic [15:0] ld;
    logic [15:0] cnt;
    logic [1:0] src;
    logic en;
    logic single;
    logic [2:0] div;
    logic imm;
    logic ie;
    logic flag;
    tcd_omode_e omode;
    logic oen;
    logic oval;
    logic pulse;
    logic tog;
  } tcd_chan_s;

  typedef struct packed {
    logic [2:0] div;
    logic [7:0] ld;
    logic [7:0] cnt;
  } tcd_psc_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } tcd_apb_req_s;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } tcd_apb_rsp_s;

  typedef struct packed {
    tcd_chan_s [NCH-1:0] ch;
    tcd_psc_s [NPS-1:0] psc;
    logic [2:0] base_cnt;
    logic [7:0] div_cnt;
    tcd_apb_rsp_s rsp;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] pin_oe;
  } tcd_state_s;

endpackage

// >>> tcd_timer.sv
// Three channel 16-bit down timer with two prescalers and an APB slave
//
// The APB slave port was chosen for this implementation.
module tcd_timer
  import tcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire tcd_apb_req_s apb_i,
  output tcd_apb_rsp_s apb_o,
  input wire logic [NCH-1:0] func_sel,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] irq_flag
);

  tcd_state_s q;
  tcd_state_s d;

  logic tin_en;
  logic [NPS-1:0] ptick;
  logic [NCH-1:0] ctick;
  logic [NCH-1:0] uflow;
  logic [NCH-1:0] wr_ld;
  logic [NCH-1:0] wr_clr;
  logic [NCH-1:0] wr_ctl;
  logic wen;

  // Low bits of the shared divider that must be zero for a tap
  function automatic logic [7:0] div_mask(input logic [2:0] c);
    logic [7:0] m;
    m = 8'hFF;
    unique case (c)
      3'h0: m = 8'h00;
      3'h1: m = 8'h03;
      3'h2: m = 8'h07;
      3'h3: m = 8'h0F;
      3'h4: m = 8'h1F;
      3'h5: m = 8'h3F;
      3'h6: m = 8'h7F;
      3'h7: m = 8'hFF;
    endcase
    return m;
  endfunction

  always_comb begin
    logic [1:0] ci;
    logic [4:0] sub;
    logic chan_hit;
    logic [15:0] wd;
    logic [DW-1:0] rd;
    logic err;
    logic own_hit;
    logic [7:0] pm;
    tcd_chan_s c;
    ci = apb_i.paddr[6:5];
    sub = apb_i.paddr[4:0];
    chan_hit = !apb_i.paddr[7] && (ci != 2'h3);
    wd = apb_i.pwdata[15:0];
    rd = '0;
    err = 1'b0;
    own_hit = 1'b0;
    pm = 8'h00;
    c = q.ch[0];
    d = q;
    // Writes commit only at the edge that completes the access phase
    wen = apb_i.psel && apb_i.penable && apb_i.pwrite && q.rsp.pready;

    d.base_cnt = q.base_cnt + 3'h1;
    tin_en = (q.base_cnt == 3'(TIN_DIV - 1));
    if (tin_en) begin
      d.div_cnt = q.div_cnt + 8'h01;
    end

    for (int p = 0; p < NPS; p++) begin
      ptick[p] = 1'b0;
      pm = div_mask(q.psc[p].div);
      if (tin_en && ((q.div_cnt & pm) == 8'h00)) begin
        if (q.psc[p].cnt == 8'h00) begin
          ptick[p] = 1'b1;
          d.psc[p].cnt = q.psc[p].ld;
        end else begin
          d.psc[p].cnt = q.psc[p].cnt - 8'h01;
        end
      end
      if (wen && (apb_i.paddr == (p == 0 ? OFF_PS0 : OFF_PS1))) begin
        d.psc[p].div = wd[PS_DIV_LSB +: 3];
        d.psc[p].ld = wd[PS_LD_LSB +: 8];
        // Restart so a new ratio takes hold at once
        d.psc[p].cnt = wd[PS_LD_LSB +: 8];
      end
    end

    for (int i = 0; i < NCH; i++) begin
      c = q.ch[i];
      pm = div_mask(c.div);
      own_hit = tin_en && ((q.div_cnt & pm) == 8'h00);
      ctick[i] = c.en && (c.src[1] ? ptick[c.src[0]] : own_hit);
      uflow[i] = ctick[i] && (c.cnt == 16'h0000);
      wr_ld[i] = wen && chan_hit && (ci == 2'(i)) && (sub == OFF_LOAD);
      wr_clr[i] = wen && chan_hit && (ci == 2'(i)) && (sub == OFF_IRQCLR);
      wr_ctl[i] = wen && chan_hit && (ci == 2'(i)) && (sub == OFF_CTRL);

      if (ctick[i]) begin
        d.ch[i].pulse = uflow[i];
        if (c.cnt != 16'h0000) begin
          d.ch[i].cnt = c.cnt - 16'h0001;
        end else if (!c.single) begin
          d.ch[i].cnt = c.ld;
        end else begin
          // Stays halted until software enables again
          d.ch[i].en = 1'b0;
        end
      end
      if (uflow[i]) begin
        d.ch[i].tog = ~c.tog;
      end
      // A new underflow with ie set wins over a clear in the same cycle
      d.ch[i].flag = (uflow[i] && c.ie) || (c.flag && !wr_clr[i]);

      if (wr_ld[i]) begin
        d.ch[i].ld = wd;
        if (c.single || c.imm) begin
          d.ch[i].cnt = wd;
        end
      end
      if (wr_ctl[i]) begin
        d.ch[i].src = wd[CTRL_SRC_LSB +: 2];
        d.ch[i].en = wd[CTRL_EN];
        d.ch[i].single = wd[CTRL_MODE];
        d.ch[i].div = wd[CTRL_DIV_LSB +: 3];
        d.ch[i].imm = wd[CTRL_IMM];
        d.ch[i].ie = wd[CTRL_IE];
      end
      if (wen && chan_hit && (ci == 2'(i)) && (sub == OFF_POUT)) begin
        d.ch[i].omode = tcd_omode_e'(wd[POUT_MODE_LSB +: 2]);
        d.ch[i].oen = wd[POUT_OE];
        d.ch[i].oval = wd[POUT_VAL];
      end

      d.pin_oe[i] = c.oen && func_sel[i];
      d.pin[i] = 1'b0;
      if (c.oen && func_sel[i]) begin
        unique case (c.omode)
          OM_LEVEL: d.pin[i] = c.oval;
          OM_PULSE: d.pin[i] = c.pulse;
          OM_TOGGLE: d.pin[i] = c.tog;
          OM_RSVD: d.pin[i] = 1'b0;
        endcase
      end
    end

    // Read decode; every access takes one wait state
    if (chan_hit) begin
      c = q.ch[ci];
      unique case (sub)
        OFF_LOAD: rd = {16'h0000, c.ld};
        OFF_COUNT: rd = {16'h0000, c.cnt};
        OFF_CTRL: rd = {22'h000000, c.src, c.en, 1'b0, c.single, c.div,
                        c.imm, c.ie};
        OFF_IRQCLR: rd = '0;
        OFF_POUT: rd = {28'h0000000, c.omode, c.oen, c.oval};
        default: err = 1'b1;
      endcase
    end else begin
      unique case (apb_i.paddr)
        OFF_PS0: rd = {16'h0000, q.psc[0].div, 5'h00, q.psc[0].ld};
        OFF_PS1: rd = {16'h0000, q.psc[1].div, 5'h00, q.psc[1].ld};
        OFF_IRQSTS: rd = {29'h00000000, q.ch[2].flag, q.ch[1].flag,
                          q.ch[0].flag};
        default: err = 1'b1;
      endcase
    end
    d.rsp.pready = apb_i.psel && apb_i.penable && !q.rsp.pready;
    d.rsp.prdata = '0;
    d.rsp.pslverr = 1'b0;
    if (d.rsp.pready) begin
      d.rsp.prdata = apb_i.pwrite ? '0 : rd;
      d.rsp.pslverr = err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign apb_o = q.rsp;
  assign pin_out = q.pin;
  assign pin_oe = q.pin_oe;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      irq_flag[i] = q.ch[i].flag;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tin_gap;
    !tin_en [*7] ##1 tin_en;
  endsequence

  chk_tin_rate: assert property (tin_en |=> s_tin_gap)
    else $error("timer input enable not every eighth cycle");

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_chk
      sequence s_zero_tick;
        ctick[g] && (q.ch[g].cnt == 16'h0000);
      endsequence

      chk_single_load: assert property (
        wr_ld[g] && q.ch[g].single
        |=> q.ch[g].cnt == $past(apb_i.pwdata[15:0]))
        else $error("single mode load not copied to counter");

      chk_imm_load: assert property (
        wr_ld[g] && !q.ch[g].single && q.ch[g].imm
        |=> q.ch[g].cnt == $past(apb_i.pwdata[15:0]))
        else $error("immediate load not copied to counter");

      chk_cyclic_reload: assert property (
        s_zero_tick and !q.ch[g].single and !wr_ld[g] and !wr_ctl[g]
        |=> (q.ch[g].cnt == $past(q.ch[g].ld)) && q.ch[g].en)
        else $error("cyclic reload at zero missing");

      chk_idle_hold: assert property (
        !q.ch[g].en && !wr_ld[g] |=> $stable(q.ch[g].cnt))
        else $error("counter moved while disabled");

      chk_irq_mask: assert property (
        $rose(q.ch[g].flag) |-> $past(q.ch[g].ie) && $past(uflow[g]))
        else $error("flag raised without enabled underflow");

      chk_flag_clear: assert property (
        wr_clr[g] && !uflow[g] |=> !q.ch[g].flag)
        else $error("flag clear write ignored");

      chk_single_halt: assert property (
        s_zero_tick and q.ch[g].single and !wr_ld[g] and !wr_ctl[g]
        |=> !q.ch[g].en && (q.ch[g].cnt == 16'h0000))
        else $error("single mode did not halt at zero");

      chk_pin_gate: assert property (
        ##1 q.pin_oe[g] == $past(q.ch[g].oen && func_sel[g]))
        else $error("pin enable not gated by enable and mux");

      chk_level_out: assert property (
        q.ch[g].oen && func_sel[g] && q.ch[g].omode == OM_LEVEL
        |=> q.pin[g] == $past(q.ch[g].oval))
        else $error("level mode pin mismatch");

      chk_toggle_out: assert property (
        q.ch[g].oen && func_sel[g] && q.ch[g].omode == OM_TOGGLE
        |=> q.pin[g] == $past(q.ch[g].tog))
        else $error("toggle mode pin mismatch");

      chk_pulse_out: assert property (
        q.ch[g].oen && func_sel[g] && q.ch[g].omode == OM_PULSE
        |=> q.pin[g] == $past(q.ch[g].pulse))
        else $error("pulse mode pin mismatch");

      chk_rsvd_out: assert property (
        q.ch[g].omode == OM_RSVD |=> !q.pin[g])
        else $error("reserved mode drove the pin high");

      chk_uflow_pulse: assert property (
        uflow[g] |=> q.ch[g].pulse)
        else $error("underflow pulse not raised");

      chk_pin_quiet: assert property (
        !(q.ch[g].oen && func_sel[g]) |=> !q.pin[g])
        else $error("pin driven while output disabled");

      chk_down_step: assert property (
        ctick[g] && (q.ch[g].cnt != 16'h0000) && !wr_ld[g]
        |=> q.ch[g].cnt == $past(q.ch[g].cnt) - 16'h0001)
        else $error("counter did not step down by one");

      chk_tick_align: assert property (
        ctick[g] |-> tin_en)
        else $error("channel tick off the timer input clock");

      chk_tick_enabled: assert property (
        ctick[g] |-> q.ch[g].en)
        else $error("channel ticked while disabled");

      chk_load_store: assert property (
        wr_ld[g] |=> q.ch[g].ld == $past(apb_i.pwdata[15:0]))
        else $error("load register write lost");

      chk_cyclic_hold: assert property (
        wr_ld[g] && !q.ch[g].single && !q.ch[g].imm && !ctick[g]
        |=> $stable(q.ch[g].cnt))
        else $error("cyclic load reached counter before zero");

      chk_flag_raise: assert property (
        uflow[g] && q.ch[g].ie |=> q.ch[g].flag)
        else $error("enabled underflow did not raise flag");
    end
  endgenerate

  generate
    for (genvar k = 0; k < NPS; k++) begin : g_psc_chk
      // A prescaler write restarts the count, so it is left out
      sequence s_psc_fire;
        ptick[k] && !wen;
      endsequence

      chk_psc_reload: assert property (
        s_psc_fire |=> q.psc[k].cnt == $past(q.psc[k].ld))
        else $error("prescaler did not reload at zero");

      chk_psc_align: assert property (
        ptick[k] |-> tin_en && (q.psc[k].cnt == 8'h00))
        else $error("prescaler tick off the input clock");
    end
  endgenerate

endmodule

// >>> tb_top.sv
// Self-checking bench for the three channel down timer
module tb_top
  import tcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  tcd_apb_req_s req;
  tcd_apb_rsp_s rsp;
  logic [NCH-1:0] func_sel;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe;
  logic [NCH-1:0] irq_flag;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int p;
  int hi;
  integer seed;
  logic [31:0] rd;
  logic [31:0] v;
  logic er;

  tcd_timer dut (
    .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
    .func_sel(func_sel), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq_flag(irq_flag)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the at most roughly 13k cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(n, rd, e);
  endtask

  function automatic logic [7:0] ca(int ch, logic [4:0] off);
    return 8'(ch * 32) + {3'h0, off};
  endfunction

  function automatic logic [15:0] ctl(logic [1:0] src, logic en, logic sg,
                                      logic [2:0] dv, logic imm, logic ie);
    return {6'h00, src, en, 1'b0, sg, dv, imm, ie};
  endfunction

  function automatic int ratio(int k);
    return (k == 0) ? 1 : (2 << k);
  endfunction

  // Pclk edges between two toggles of a channel pin
  task automatic period(int ch, output int n);
    logic last;
    @(posedge pclk);
    last = pin_out[ch];
    while (pin_out[ch] === last) @(posedge pclk);
    last = pin_out[ch];
    n = 0;
    while (pin_out[ch] === last) begin
      @(posedge pclk);
      n++;
    end
  endtask

  initial begin
    seed = 32'hC4B1;
    req = '0;
    func_sel = '1;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      rchk("load rst", ca(c, OFF_LOAD), 32'h00000000);
      rchk("ctrl rst", ca(c, OFF_CTRL), 32'h00000000);
      rchk("pout rst", ca(c, OFF_POUT), 32'h00000000);
      v = $random(seed);
      wr(ca(c, OFF_LOAD), v[15:0]);
      rchk("load rw", ca(c, OFF_LOAD), {16'h0000, v[15:0]});
      wr(ca(c, OFF_COUNT), ~v[15:0]);
      rchk("count ro", ca(c, OFF_COUNT), 32'h00000000);
    end
    rchk("ps0 rst", OFF_PS0, 32'h00000000);
    rchk("ps1 rst", OFF_PS1, 32'h00000000);
    apb(1'b0, 8'h60, 32'h00000000);
    chk("unmapped err", {31'h0, er}, 32'h00000001);
    $display("test done: reset and access");
    wr(ca(0, OFF_CTRL), ctl(2'b00, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
    wr(ca(0, OFF_LOAD), 16'h1234);
    rchk("single load", ca(0, OFF_COUNT), 32'h00001234);
    wr(ca(0, OFF_CTRL), ctl(2'b00, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0));
    wr(ca(0, OFF_LOAD), 16'h0003);
    rchk("imm load", ca(0, OFF_COUNT), 32'h00000003);
    wr(ca(0, OFF_CTRL), ctl(2'b00, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1));
    wr(ca(0, OFF_LOAD), 16'h0007);
    rchk("late load", ca(0, OFF_COUNT), 32'h00000003);
    wr(ca(0, OFF_POUT), 16'h000A);
    wr(ca(0, OFF_CTRL), ctl(2'b00, 1'b1, 1'b0, 3'h0, 1'b0, 1'b1));
    period(0, p);
    chk("cyc period", 32'(p), 32'h00000040);
    chk("flag up", {31'h0, irq_flag[0]}, 32'h00000001);
    v = $random(seed);
    wr(ca(0, OFF_IRQCLR), v[15:0]);
    repeat (2) @(posedge pclk);
    chk("flag clr", {31'h0, irq_flag[0]}, 32'h00000000);
    rchk("irq sts", OFF_IRQSTS, 32'h00000000);
    wr(ca(0, OFF_CTRL), 16'h0000);
    apb(1'b0, ca(0, OFF_COUNT), 32'h00000000);
    v = rd;
    repeat (40) @(posedge pclk);
    rchk("stopped", ca(0, OFF_COUNT), v);
    $display("test done: load modes and cyclic");
    wr(ca(1, OFF_LOAD), 16'h0000);
    wr(ca(1, OFF_POUT), 16'h000A);
    for (int k = 0; k < 8; k++) begin
      wr(ca(1, OFF_CTRL), ctl(2'b00, 1'b1, 1'b0, 3'(k), 1'b0, 1'b0));
      period(1, p);
      chk("div period", 32'(p), 32'(8 * ratio(k)));
    end
    chk("masked", {31'h0, irq_flag[1]}, 32'h00000000);
    for (int s = 0; s < NPS; s++) begin
      v = $random(seed);
      wr(s ? OFF_PS1 : OFF_PS0, {1'b0, v[14:13], 10'h000, v[2:0]});
      wr(ca(1, OFF_CTRL), ctl({1'b1, 1'(s)}, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0));
      period(1, p);
      chk("psc period", 32'(p),
          32'(8 * ratio(int'(v[14:13])) * (int'(v[2:0]) + 1)));
    end
    wr(ca(1, OFF_CTRL), ctl(2'b01, 1'b1, 1'b0, 3'h2, 1'b0, 1'b0));
    period(1, p);
    chk("src div", 32'(p), 32'h00000040);
    $display("test done: dividers and prescalers");
    wr(ca(2, OFF_LOAD), 16'h0000);
    wr(ca(2, OFF_CTRL), ctl(2'b00, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0));
    for (int b = 0; b < 2; b++) begin
      wr(ca(2, OFF_POUT), {14'h0000, 1'b1, 1'(b)});
      repeat (20) @(posedge pclk);
      chk("level", {31'h0, pin_out[2]}, 32'(b));
      chk("oe on", {31'h0, pin_oe[2]}, 32'h00000001);
    end
    wr(ca(2, OFF_POUT), 16'h0001);
    repeat (4) @(posedge pclk);
    chk("oe off", {30'h0, pin_oe[2], pin_out[2]}, 32'h00000000);
    wr(ca(2, OFF_POUT), 16'h0003);
    func_sel <= 3'b011;
    repeat (4) @(posedge pclk);
    chk("unmuxed", {31'h0, pin_oe[2]}, 32'h00000000);
    func_sel <= 3'b111;
    wr(ca(2, OFF_LOAD), 16'h0003);
    wr(ca(2, OFF_POUT), 16'h0006);
    repeat (40) @(posedge pclk);
    hi = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      hi += int'(pin_out[2]);
    end
    chk("pulse hi", 32'(hi), 32'h00000010);
    $display("test done: pin output");
    wr(ca(2, OFF_CTRL), ctl(2'b00, 1'b0, 1'b1, 3'h0, 1'b0, 1'b1));
    wr(ca(2, OFF_LOAD), 16'h0002);
    wr(ca(2, OFF_CTRL), ctl(2'b00, 1'b1, 1'b1, 3'h0, 1'b0, 1'b1));
    for (int i = 0; i < 200 && irq_flag[2] !== 1'b1; i++) @(posedge pclk);
    chk("single flag", {31'h0, irq_flag[2]}, 32'h00000001);
    wr(ca(2, OFF_IRQCLR), 16'h0000);
    repeat (100) @(posedge pclk);
    chk("single clr", {31'h0, irq_flag[2]}, 32'h00000000);
    rchk("single cnt", ca(2, OFF_COUNT), 32'h00000000);
    rchk("single off", ca(2, OFF_CTRL),
         {16'h0000, ctl(2'b00, 1'b0, 1'b1, 3'h0, 1'b0, 1'b1)});
    $display("test done: single mode");
    final_report();
  end
endmodule
